//--- core/wt_cache_ctrl.sv
// Write-through direct-mapped cache controller with snoop and diagnostic access
//
// Functional notes
// - Cache RAM written only on write hit, fill or diagnostic write
// - Read miss loads whole four-byte block
// - Sequential word fetches hit every second read
// - Sequencer starts on cycle, ends on ready
// - 8K local RAM, all diag reachable
// - Read hit served from cache only
// - Read miss reads memory, updates tag
// - Write hit writes cache and memory
// - Write miss writes memory only
// - Request bus when not owned
// - Snooped foreign write hit invalidates tag
// - Tag diagnostic access is words only
// - Cache RAM diag allows bytes and words
// - Tag holds page D0-D11, valid D12
// - Valid flag low means valid
// - Ready from sync readies or early ack
// - Ready phases aligned to strobe, ready
// - Direct-mapped 4K cache, four-byte blocks
// - Offset field picks line and tag
// - Hit is page match and valid
`timescale 1ns/1ps
module wt_cache_ctrl
  import wt_cache_pkg::*;
(
  input  wire logic        sys_clk,         // Board clock 20 MHz
  input  wire logic        rst,             // Async reset, high
  input  wire logic        cpu_start,       // Processor cycle start strobe
  input  wire cpu_req_t    cpu_req,         // Processor request
  input  wire logic [11:0] xlat_page,       // Translated page number
  output logic [15:0]      cpu_rdata,       // Read data to processor
  output logic             cpu_ready,       // Processor ready
  input  wire logic        local_bus_sync_ready, // Local bus ready
  input  wire logic        bus_owned,       // Board holds system bus
  input  wire logic        bus_grant,       // Arbiter grant pin
  output logic             bus_ownership_request, // Bus request
  output logic             bus_cmd_valid,   // Bus command active
  output logic             bus_cmd_write,   // Command is write
  output logic             bus_cmd_io,      // Command is I/O
  output sys_addr_t        bus_addr,        // Bus address
  output logic [1:0]       bus_byte_en,     // Byte enables hi, lo
  output logic [15:0]      bus_wdata,       // Bus write data
  input  wire logic [31:0] bus_rdata,       // Bus read data (block)
  input  wire logic        bus_advance_acknowledge, // Early ack pin
  input  wire logic        snoop_write,     // Foreign memory write pin
  input  wire logic [23:0] snoop_addr       // Foreign write address
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOOKUP = 3'b001,
    ST_REQ    = 3'b010,
    ST_BUS    = 3'b011,
    ST_DONE   = 3'b100,
    ST_WAIT   = 3'b101
  } seq_state_t;

  seq_state_t  state;
  seq_state_t  next_state;
  cpu_req_t    req;
  logic [12:0] tag_ram [LINE_COUNT];
  logic [7:0]  lram [LRAM_BYTES];
  logic [12:0] tag_rd;
  logic [2:0]  grant_sync;
  logic [2:0]  ack_sync;
  logic [2:0]  snp_sync;
  logic [23:0] snp_addr_q;
  logic        cache_sync_ready;
  logic        tag_translation_sync_ready;
  logic        phase2;

  wire         grant_s = grant_sync[1];
  wire         ack_s   = ack_sync[1];
  wire         snp_rise = snp_sync[1] & ~snp_sync[2];
  wire [9:0]   line    = req.addr[11:2];
  wire         hit     = (tag_rd[11:0] == xlat_page)
                         & (tag_rd[TAG_VALID_BIT] == TAG_VALID);
  wire         is_rd   = req.kind == REQ_MEM_RD;
  wire         is_wr   = req.kind == REQ_MEM_WR;
  wire         is_io   = req.kind == REQ_BUS_IO;
  wire         is_diag = req.kind == REQ_DIAG;
  wire         need_bus = is_io | is_wr | (is_rd & ~hit);
  wire         in_bus   = (state == ST_BUS);
  wire         fill     = in_bus & is_rd & ack_s & phase2;
  wire [12:0]  l_base   = {1'b0, line, 2'b00};
  wire [12:0]  d_addr   = {req.addr[12:1], 1'b0};
  wire [9:0]   snp_line = snp_addr_q[11:2];
  wire [9:0]   d_line   = req.addr[10:1];
  wire         snp_hit  = snp_rise & (tag_ram[snp_line][11:0] == snp_addr_q[23:12])
                          & (tag_ram[snp_line][TAG_VALID_BIT] == TAG_VALID);
  wire         busy_cyc = (state != ST_IDLE) & (state != ST_WAIT);

  ready_gen u_ready (
    .sys_clk                    (sys_clk),
    .rst                        (rst),
    .mapped_address_latch_strobe(cpu_start),
    .local_bus_sync_ready       (local_bus_sync_ready),
    .tag_translation_sync_ready (tag_translation_sync_ready),
    .cache_sync_ready           (cache_sync_ready),
    .bus_completion_state       (in_bus),
    .bus_advance_acknowledge    (ack_s),
    .phase2                     (phase2),
    .cpu_ready                  (cpu_ready)
  );

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (cpu_start) next_state = ST_LOOKUP;
      ST_LOOKUP: if (is_diag) next_state = ST_DONE;
                 else if (need_bus) next_state = ST_REQ;
                 else next_state = ST_DONE;
      ST_REQ:    if (bus_owned | grant_s) next_state = ST_BUS;
      ST_BUS:    if (ack_s & phase2) next_state = ST_WAIT;
      ST_DONE:   next_state = ST_WAIT;
      ST_WAIT:   if (cpu_ready) next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      grant_sync <= 3'h0;
      ack_sync   <= 3'h0;
      snp_sync   <= 3'h0;
      snp_addr_q <= 24'h000000;
    end
    else
    begin
      state      <= next_state;
      grant_sync <= {grant_sync[1:0], bus_grant};
      ack_sync   <= {ack_sync[1:0], bus_advance_acknowledge};
      snp_sync   <= {snp_sync[1:0], snoop_write};
      snp_addr_q <= snoop_addr;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      req <= '0;
    else if (state == ST_IDLE && cpu_start)
      req <= cpu_req;
  end

  always_ff @(posedge sys_clk)
    tag_rd <= tag_ram[cpu_req.addr[11:2]];

  // Tag array updates; snoop invalidate before fill
  always_ff @(posedge sys_clk)
  begin
    if (snp_hit)
      tag_ram[snp_line][TAG_VALID_BIT] <= TAG_INVALID;
    if (fill)
      tag_ram[line] <= {TAG_VALID, xlat_page};
    else if (state == ST_LOOKUP && is_diag && req.diag_tag && req.io_write)
      tag_ram[d_line] <= req.wdata[12:0];
  end

  // Local RAM: fill, write hit, diagnostics
  always_ff @(posedge sys_clk)
  begin
    if (fill)
    begin
      for (int b = 0; b < 4; b++)
        lram[l_base + 13'(b)] <= bus_rdata[8*b +: 8];
    end
    else if (state == ST_LOOKUP && is_wr && hit)
    begin
      if (req.byte_lo_en)
        lram[l_base + 13'(req.addr[1:0])] <= req.wdata[7:0];
      if (req.byte_hi_en)
        lram[l_base + 13'(req.addr[1:0]) + 13'h1] <= req.wdata[15:8];
    end
    else if (state == ST_LOOKUP && is_diag && !req.diag_tag && req.io_write)
    begin
      if (req.byte_lo_en)
        lram[d_addr] <= req.wdata[7:0];
      if (req.byte_hi_en)
        lram[d_addr + 13'h1] <= req.wdata[15:8];
    end
  end

  // Read data, sync readies
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_rdata                  <= 16'h0000;
      cache_sync_ready           <= 1'b0;
      tag_translation_sync_ready <= 1'b0;
    end
    else
    begin
      cache_sync_ready           <= (state == ST_LOOKUP) & (is_diag | ~need_bus);
      tag_translation_sync_ready <= 1'b0;
      if (state == ST_LOOKUP && is_diag && req.diag_tag)
        cpu_rdata <= {3'h0, tag_ram[d_line]};
      else if (state == ST_LOOKUP && is_diag)
        cpu_rdata <= {lram[d_addr + 13'h1], lram[d_addr]};
      else if (state == ST_LOOKUP && is_rd && hit)
        cpu_rdata <= {lram[l_base + 13'(req.addr[1:0]) + 13'h1],
                      lram[l_base + 13'(req.addr[1:0])]};
      else if (fill)
        cpu_rdata <= req.addr[1] ? bus_rdata[31:16] : bus_rdata[15:0];
    end
  end

  // Bus command outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_ownership_request <= 1'b0;
      bus_cmd_valid         <= 1'b0;
      bus_cmd_write         <= 1'b0;
      bus_cmd_io            <= 1'b0;
      bus_addr              <= '0;
      bus_byte_en           <= 2'h0;
      bus_wdata             <= 16'h0000;
    end
    else
    begin
      bus_ownership_request <= (next_state == ST_REQ) & ~bus_owned;
      bus_cmd_valid         <= (next_state == ST_BUS);
      bus_cmd_write         <= is_wr | (is_io & req.io_write);
      bus_cmd_io            <= is_io;
      bus_addr              <= is_rd ? {xlat_page, line, 2'b00} : {xlat_page, req.addr[11:0]};
      bus_byte_en           <= is_rd ? 2'h3 : {req.byte_hi_en, req.byte_lo_en};
      bus_wdata             <= req.wdata;
    end
  end
endmodule // wt_cache_ctrl

//--- core/wt_cache_pkg.sv
// Package with constants and carrier types for the write-through cache controller
package wt_cache_pkg;
  localparam int          CPU_ADDR_W     = 24;
  localparam int          PAGE_W         = 12;
  localparam int          LINE_W         = 10;
  localparam int          LINE_COUNT     = 1024;
  localparam int          LRAM_ADDR_W    = 13;
  localparam int          LRAM_BYTES     = 8192;
  localparam int          TAG_W          = 13;
  localparam int          TAG_VALID_BIT  = 12;
  localparam logic        TAG_VALID      = 1'b0;
  localparam logic        TAG_INVALID    = 1'b1;
  localparam logic [12:0] TAG_RESET      = 13'h1000;
  localparam int          BYTE_SEL_W     = 2;
  localparam logic        DIAG_SPACE_TAG = 1'b1;
  localparam logic        DIAG_SPACE_RAM = 1'b0;

  typedef enum logic [1:0] {
    REQ_MEM_RD = 2'b00,
    REQ_MEM_WR = 2'b01,
    REQ_BUS_IO = 2'b10,
    REQ_DIAG   = 2'b11
  } req_kind_t;

  typedef struct packed {
    req_kind_t   kind;
    logic        io_write;
    logic        diag_tag;
    logic [23:0] addr;
    logic        byte_hi_en;
    logic        byte_lo_en;
    logic [15:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [11:0] page;
    logic [9:0]  line;
    logic [1:0]  byte_sel;
  } sys_addr_t;
endpackage

//--- core/ready_gen.sv
// Processor ready generator with two-phase clocking
`timescale 1ns/1ps
module ready_gen
  import wt_cache_pkg::*;
(
  input  wire logic sys_clk,                  // Board clock
  input  wire logic rst,                      // Async reset, high
  input  wire logic mapped_address_latch_strobe, // Cycle start strobe
  input  wire logic local_bus_sync_ready,     // Local bus done
  input  wire logic tag_translation_sync_ready, // Tag path done
  input  wire logic cache_sync_ready,         // Cache path done
  input  wire logic bus_completion_state,     // Bus cycle in completion
  input  wire logic bus_advance_acknowledge,  // Synchronised early ack
  output logic      phase2,                   // Second clock phase
  output logic      cpu_ready                 // Ready to processor
);
  logic next_phase2;
  wire  bus_done;
  wire  any_sync;

  // Phase realigns on each strobe and each ready
  assign next_phase2 = (mapped_address_latch_strobe | cpu_ready) ? 1'b0 : ~phase2;
  assign bus_done    = bus_completion_state & phase2 & bus_advance_acknowledge;
  assign any_sync    = local_bus_sync_ready | tag_translation_sync_ready | cache_sync_ready;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase2    <= 1'b0;
      cpu_ready <= 1'b0;
    end
    else
    begin
      phase2    <= next_phase2;
      cpu_ready <= (any_sync | bus_done) & ~cpu_ready;
    end
  end
endmodule // ready_gen

//--- testbench/wt_cache_checker.sv
// Port checker for the cache controller
`timescale 1ns/1ps
module wt_cache_checker
  import wt_cache_pkg::*;
(
  input wire logic        sys_clk, // Clock
  input wire logic        rst, // Reset
  input wire logic        cpu_start, // Start
  input wire cpu_req_t    cpu_req, // Request
  input wire logic [11:0] xlat_page, // Page
  input wire logic [15:0] cpu_rdata, // Data
  input wire logic        cpu_ready, // Ready
  input wire logic        local_bus_sync_ready, // Local
  input wire logic        bus_owned, // Owned
  input wire logic        bus_grant, // Grant
  input wire logic        bus_ownership_request, // Req
  input wire logic        bus_cmd_valid, // Valid
  input wire logic        bus_cmd_write, // Write
  input wire logic        bus_cmd_io, // Io
  input wire sys_addr_t   bus_addr, // Addr
  input wire logic [1:0]  bus_byte_en, // Enables
  input wire logic [15:0] bus_wdata, // Wdata
  input wire logic [31:0] bus_rdata, // Block
  input wire logic        bus_advance_acknowledge, // Ack
  input wire logic        snoop_write, // Snoop
  input wire logic [23:0] snoop_addr // Snoop addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence diag_go;
    cpu_start && cpu_req.kind == REQ_DIAG;
  endsequence
  sequence mem_cmd;
    bus_cmd_valid && !bus_cmd_io;
  endsequence
  a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
    else $error("ready longer than one cycle");
  a_diag_done: assert property (diag_go |-> ##[2:5] cpu_ready)
    else $error("diag cycle not finished");
  a_diag_no_bus: assert property (diag_go |=> (!bus_ownership_request && !bus_cmd_valid) [*4])
    else $error("diag cycle used bus");
  a_no_req_owned: assert property (bus_owned && $past(bus_owned) |-> !bus_ownership_request)
    else $error("request while owned");
  a_write_through: assert property (cpu_start && cpu_req.kind == REQ_MEM_WR |-> ##[1:60] mem_cmd ##0 bus_cmd_write)
    else $error("write not sent to memory");
  a_wdata_pass: assert property (mem_cmd ##0 bus_cmd_write |-> bus_wdata == cpu_req.wdata)
    else $error("bus write data wrong");
  a_line_page: assert property (mem_cmd |-> bus_addr.page == xlat_page && bus_addr.line == cpu_req.addr[11:2])
    else $error("bus address wrong");
  a_ack_first: assert property (bus_cmd_valid && !bus_advance_acknowledge |-> !cpu_ready)
    else $error("ready before ack");
  a_ack_ready: assert property ($rose(bus_advance_acknowledge) |-> ##[2:12] cpu_ready)
    else $error("no ready after ack");
  a_io_flag: assert property (bus_cmd_valid |-> bus_cmd_io == (cpu_req.kind == REQ_BUS_IO))
    else $error("bus io flag wrong");
  a_fill_block: assert property (bus_cmd_valid && cpu_req.kind == REQ_MEM_RD |-> bus_byte_en == 2'h3 && bus_addr.byte_sel == 2'h0)
    else $error("fill not whole block");
endmodule // wt_cache_checker

bind wt_cache_ctrl wt_cache_checker u_chk (.sys_clk(sys_clk), .rst(rst), .cpu_start(cpu_start),
  .cpu_req(cpu_req), .xlat_page(xlat_page), .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready),
  .local_bus_sync_ready(local_bus_sync_ready), .bus_owned(bus_owned), .bus_grant(bus_grant),
  .bus_ownership_request(bus_ownership_request), .bus_cmd_valid(bus_cmd_valid),
  .bus_cmd_write(bus_cmd_write), .bus_cmd_io(bus_cmd_io), .bus_addr(bus_addr),
  .bus_byte_en(bus_byte_en), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_advance_acknowledge(bus_advance_acknowledge), .snoop_write(snoop_write),
  .snoop_addr(snoop_addr));

//--- testbench/sys_mem_model.sv
// System bus arbiter and memory model
`timescale 1ns/1ps
module sys_mem_model
  import wt_cache_pkg::*;
(
  input  wire logic        sys_clk, // Clock
  input  wire logic        rst, // Reset
  input  wire logic [3:0]  ack_dly, // Wait states
  input  wire logic        bus_ownership_request, // Req
  input  wire logic        bus_cmd_valid, // Valid
  input  wire logic        bus_cmd_write, // Write
  input  wire sys_addr_t   bus_addr, // Addr
  input  wire logic [15:0] bus_wdata, // Wdata
  output logic             bus_grant, // Grant
  output logic             bus_owned, // Owned
  output logic             bus_advance_acknowledge, // Ack
  output logic [31:0]      bus_rdata // Block
);
  logic [3:0]  wait_cnt;
  logic [15:0] last_wd;
  function automatic logic [31:0] mw(logic [11:0] p, logic [9:0] l);
    return {4'h0, p, l, 6'h15};
  endfunction
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      bus_grant <= 1'b0;
      bus_owned <= 1'b0;
      wait_cnt <= 4'h0;
      bus_advance_acknowledge <= 1'b0;
      last_wd <= 16'h0;
    end
    else
    begin
      bus_grant <= bus_ownership_request;
      bus_owned <= (bus_owned | bus_grant) & !(bus_advance_acknowledge & !bus_cmd_valid);
      wait_cnt <= bus_cmd_valid ? wait_cnt + 4'h1 : 4'h0;
      bus_advance_acknowledge <= bus_cmd_valid && wait_cnt >= ack_dly;
      if (bus_cmd_valid && bus_cmd_write)
        last_wd <= bus_wdata;
    end
  // Released bus shows the inverted block
  assign bus_rdata = bus_advance_acknowledge ? mw(bus_addr.page, bus_addr.line) : ~mw(bus_addr.page, bus_addr.line);
endmodule // sys_mem_model

//--- testbench/tb_top.sv
// Self-checking bench for the cache controller
`timescale 1ns/1ps
module tb_top;
  import wt_cache_pkg::*;
  typedef struct {req_kind_t k; logic w, t; logic [23:0] a; logic [1:0] be;
    logic [15:0] d; logic [11:0] pg; logic [15:0] ed, m; logic eb;} row_t;
  localparam logic [11:0] PG = 12'h2a5;
  logic        sys_clk = 1'b0, rst = 1'b1, cpu_start = 1'b0, snoop_write = 1'b0, local_bus_sync_ready = 1'b0;
  logic        cpu_ready, bus_owned, bus_grant, bus_ownership_request, bus_seen;
  logic        bus_cmd_valid, bus_cmd_write, bus_cmd_io, bus_advance_acknowledge;
  cpu_req_t    cpu_req = '0;
  sys_addr_t   bus_addr;
  logic [11:0] xlat_page = 12'h0;
  logic [23:0] snoop_addr = 24'h0;
  logic [15:0] cpu_rdata, bus_wdata;
  logic [31:0] bus_rdata, blk;
  logic [3:0]  ack_dly = 4'h1;
  logic [1:0]  bus_byte_en;
  int          err_total = 0, n_checks = 0;
  row_t        rows[12];
  wt_cache_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .cpu_start(cpu_start), .cpu_req(cpu_req),
    .xlat_page(xlat_page), .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready), .local_bus_sync_ready(local_bus_sync_ready),
    .bus_owned(bus_owned), .bus_grant(bus_grant), .bus_ownership_request(bus_ownership_request),
    .bus_cmd_valid(bus_cmd_valid), .bus_cmd_write(bus_cmd_write), .bus_cmd_io(bus_cmd_io),
    .bus_addr(bus_addr), .bus_byte_en(bus_byte_en), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_advance_acknowledge(bus_advance_acknowledge), .snoop_write(snoop_write), .snoop_addr(snoop_addr));
  sys_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .ack_dly(ack_dly),
    .bus_ownership_request(bus_ownership_request), .bus_cmd_valid(bus_cmd_valid),
    .bus_cmd_write(bus_cmd_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_grant(bus_grant),
    .bus_owned(bus_owned), .bus_advance_acknowledge(bus_advance_acknowledge), .bus_rdata(bus_rdata));
  initial forever #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (bus_cmd_valid === 1'b1) bus_seen = 1'b1;
  task automatic chk_d(logic [15:0] g, logic [15:0] e, logic [15:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask
  task automatic chk_b(logic g, logic e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic run(row_t r);
    logic got;
    @(posedge sys_clk);
    cpu_start <= 1'b1;
    cpu_req <= '{r.k, r.w, r.t, r.a, r.be[1], r.be[0], r.d};
    xlat_page <= r.pg;
    bus_seen = 1'b0;
    got = 1'b0;
    @(posedge sys_clk);
    cpu_start <= 1'b0;
    for (int i = 0; i < 300 && !got; i++)
    begin
      @(negedge sys_clk);
      got = (cpu_ready === 1'b1);
    end
    chk_b(got, 1'b1);
    chk_d(cpu_rdata, r.ed, r.m);
    chk_b(bus_seen, r.eb);
    if (r.k == REQ_MEM_WR)
      chk_d(u_mem.last_wd, r.d, 16'hffff);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    blk = u_mem.mw(PG, 10'h015);
    rows = '{'{REQ_DIAG, 1, 1, 24'h2a, 3, 16'h1000, PG, 0, 0, 0},
      '{REQ_DIAG, 1, 0, 24'h1ffe, 3, 16'hbeef, PG, 0, 0, 0},
      '{REQ_DIAG, 1, 0, 24'h1ffe, 1, 16'h0011, PG, 0, 0, 0},
      '{REQ_DIAG, 0, 0, 24'h1ffe, 3, 0, PG, 16'hbe11, 16'hffff, 0},
      '{REQ_MEM_RD, 0, 0, 24'h54, 3, 0, PG, blk[15:0], 16'hffff, 1},
      '{REQ_MEM_RD, 0, 0, 24'h56, 3, 0, PG, blk[31:16], 16'hffff, 0},
      '{REQ_DIAG, 0, 1, 24'h2a, 3, 0, PG, 16'h02a5, 16'h1fff, 0},
      '{REQ_MEM_WR, 0, 0, 24'h54, 3, 16'h1234, PG, 0, 0, 1},
      '{REQ_DIAG, 0, 0, 24'h54, 3, 0, PG, 16'h1234, 16'hffff, 0},
      '{REQ_MEM_WR, 0, 0, 24'h56, 3, 16'h9999, 12'h111, 0, 0, 1},
      '{REQ_DIAG, 0, 0, 24'h56, 3, 0, PG, blk[31:16], 16'hffff, 0},
      '{REQ_BUS_IO, 1, 0, 24'h80, 3, 16'h0005, PG, 0, 0, 1}};
    repeat (2) @(posedge sys_clk);
    chk_b(cpu_ready, 1'b0);
    chk_b(bus_ownership_request, 1'b0);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    // Local bus ready alone must raise processor ready
    @(posedge sys_clk);
    local_bus_sync_ready <= 1'b1;
    @(posedge sys_clk);
    local_bus_sync_ready <= 1'b0;
    @(negedge sys_clk);
    chk_b(cpu_ready, 1'b1);
    @(negedge sys_clk);
    chk_b(cpu_ready, 1'b0);
    // Reset in mid-run while idle
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_b(cpu_ready, 1'b0);
    chk_b(bus_cmd_valid, 1'b0);
    chk_b(bus_ownership_request, 1'b0);
    rst <= 1'b0;
    @(posedge sys_clk);
    snoop_addr <= {PG, 10'h015, 2'b00};
    snoop_write <= 1'b1;
    repeat (6) @(posedge sys_clk);
    snoop_write <= 1'b0;
    repeat (4) @(posedge sys_clk);
    run('{REQ_DIAG, 0, 1, 24'h2a, 3, 0, PG, 16'h12a5, 16'h1fff, 0});
    ack_dly <= 4'h9;
    run('{REQ_MEM_RD, 0, 0, 24'h54, 3, 0, PG, blk[15:0], 16'hffff, 1});
    report_and_stop();
  end
endmodule // tb_top
